/* File: design/sufp_frame_packer.sv */
// uplink frame packer: header build, group serialiser and output byte fifo
`timescale 1ns/1ps

// ----------------------------------------------------------------
// output fifo
// ----------------------------------------------------------------
module sufp_fifo
	import sufp_pkg::*;
#(
	parameter int unsigned WIDTH = FIFO_WIDTH,
	parameter int unsigned DEPTH = FIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic  [$clog2(DEPTH):0] level
);
	localparam int unsigned AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_cfg
		$error("sufp_fifo: depth must be a power of two of at least 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 cnt;
	} sufp_fifo_st_t;

	sufp_fifo_st_t st_reg;
	sufp_fifo_st_t st_next;
	logic          push;
	logic          pop;

	assign in_ready  = (st_reg.cnt != DEPTH[AW:0]);
	assign out_valid = (st_reg.cnt != '0);
	assign out_data  = st_reg.mem[st_reg.rd];
	assign level     = st_reg.cnt;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.mem[st_reg.wr] = in_data;
			st_next.wr             = st_reg.wr + 1'b1;
		end
		if (pop) begin
			st_next.rd = st_reg.rd + 1'b1;
		end
		case ({push, pop})
			2'b10:   st_next.cnt = st_reg.cnt + 1'b1;
			2'b01:   st_next.cnt = st_reg.cnt - 1'b1;
			default: st_next.cnt = st_reg.cnt;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule : sufp_fifo

// ----------------------------------------------------------------
// frame packer top
// ----------------------------------------------------------------
module sufp_frame_packer
	import sufp_pkg::*;
#(
	parameter int unsigned DEPTH = FIFO_DEPTH
) (
	input  wire logic              clk,
	input  wire logic              arst_n,
	input  wire logic              grp_valid,
	output logic                   grp_ready,
	input  wire logic [IQ_W-1:0]   grp_i,
	input  wire logic [IQ_W-1:0]   grp_q,
	input  wire logic [MIC_W-1:0]  grp_mic,
	input  wire logic              push_to_talk_n,
	input  wire logic              dash_n,
	input  wire logic              pwr_valid,
	input  wire logic [15:0]       fwd_pwr,
	input  wire logic [15:0]       rev_pwr,
	input  wire logic              freq_valid,
	input  wire logic [31:0]       freq_count,
	input  wire logic [15:0]       pport_in,
	input  wire logic [7:0]        user_in,
	output logic                   out_valid,
	input  wire logic              out_ready,
	output logic [7:0]             out_data,
	output logic                   out_sof
);
	localparam int unsigned LW = $clog2(DEPTH) + 1;

	if (DEPTH < 2 || DEPTH > 128) begin : g_bad_depth
		$error("sufp_frame_packer: fifo depth must lie in 2..128");
	end

	typedef struct packed {
		sufp_state_t        state;
		logic [2:0]         hdr_pos;
		logic [5:0]         grp_cnt;
		logic [2:0]         byte_pos;
		logic               have_grp;
		logic [GRP_W-1:0]   grp;
		logic [39:0]        ctrl;
		logic [2:0]         sched;
		logic               pwr_avail;
		logic               freq_avail;
		logic [31:0]        pwr;
		logic [31:0]        freq;
		logic [7:0]         full_cnt;
		logic [7:0]         wait_cnt;
		logic [7:0]         seq_cnt;
		logic [2:0]         ptt_sync;
		logic [2:0]         dash_sync;
		logic               ptt_lvl;
		logic               dash_lvl;
	} sufp_st_t;

	sufp_st_t          st_reg;
	sufp_st_t          st_next;
	logic              wr_valid;
	logic              wr_ready;
	logic [8:0]        wr_data;
	logic [LW-1:0]     fifo_level;
	logic [8:0]        rd_data;
	logic [7:0]        cb [0:4];
	logic [2:0]        page;
	logic [2:0]        cidx;
	logic              zeros_after;

	assign out_data  = rd_data[7:0];
	assign out_sof   = rd_data[8];
	assign grp_ready = (st_reg.state == SUFP_SAMP) && !st_reg.have_grp;
	assign cidx      = st_reg.hdr_pos - CTRL_FIRST;

	// ----------------------------------------------------------------
	// control bytes for the next frame
	// ----------------------------------------------------------------
	always_comb begin
		zeros_after = 1'b1;
		page = st_reg.sched;
		if ((page == PAGE_POWER && !st_reg.pwr_avail) ||
			(page == PAGE_FREQ && !st_reg.freq_avail)) begin
			page = PAGE_DEBUG;
		end
		cb[0] = 8'h00;
		cb[0][PTT_BIT]  = ~st_reg.ptt_lvl;
		cb[0][DASH_BIT] = ~st_reg.dash_lvl;
		cb[0][7:SEL_LSB] = {3'b000, page};
		case (page)
			PAGE_POWER: begin
				{cb[1], cb[2], cb[3], cb[4]} = st_reg.pwr;
			end
			PAGE_PPORT: begin
				{cb[1], cb[2], cb[3], cb[4]} = {pport_in, 16'h0000};
			end
			PAGE_FREQ: begin
				{cb[1], cb[2], cb[3], cb[4]} = st_reg.freq;
			end
			PAGE_USER: begin
				{cb[1], cb[2], cb[3], cb[4]} = {user_in, 24'h00_0000};
			end
			default: begin
				cb[1] = st_reg.full_cnt;
				cb[2] = st_reg.wait_cnt;
				cb[3] = st_reg.seq_cnt;
				cb[4] = {{(8 - LW){1'b0}}, fifo_level};
			end
		endcase
		// a sync lead followed only by zeros up to the last control byte becomes SYNC_SAFE
		for (int k = 1; k <= 4; k++) begin
			zeros_after = 1'b1;
			for (int m = k + 1; m <= 4; m++) begin
				if (cb[m] != SYNC_TAIL) begin
					zeros_after = 1'b0;
				end
			end
			if (cb[k] == SYNC_LEAD && zeros_after) begin
				cb[k] = SYNC_SAFE;
			end
		end
	end

	// ----------------------------------------------------------------
	// frame sequencer
	// ----------------------------------------------------------------
	always_comb begin
		st_next  = st_reg;
		wr_valid = 1'b0;
		wr_data  = 9'h000;

		// pins are asynchronous: act only once stages two and three agree
		st_next.ptt_sync  = {st_reg.ptt_sync[1:0], push_to_talk_n};
		st_next.dash_sync = {st_reg.dash_sync[1:0], dash_n};
		if (st_reg.ptt_sync[1] == st_reg.ptt_sync[2]) begin
			st_next.ptt_lvl = st_reg.ptt_sync[2];
		end
		if (st_reg.dash_sync[1] == st_reg.dash_sync[2]) begin
			st_next.dash_lvl = st_reg.dash_sync[2];
		end

		// new measurements stay pending until a frame carries them
		if (pwr_valid) begin
			st_next.pwr = {fwd_pwr, rev_pwr};
		end
		if (freq_valid) begin
			st_next.freq = freq_count;
		end

		case (st_reg.state)
			SUFP_IDLE: begin
				if (grp_valid) begin
					st_next.ctrl    = {cb[0], cb[1], cb[2], cb[3], cb[4]};
					st_next.hdr_pos = 3'h0;
					st_next.state   = SUFP_HEAD;
					st_next.sched   = (st_reg.sched == PAGE_USER) ? PAGE_DEBUG
						: st_reg.sched + 1'b1;
					if (page == PAGE_POWER) begin
						st_next.pwr_avail = 1'b0;
					end
					if (page == PAGE_FREQ) begin
						st_next.freq_avail = 1'b0;
					end
				end
			end
			SUFP_HEAD: begin
				wr_valid = 1'b1;
				if (st_reg.hdr_pos == 3'h0) begin
					wr_data = {1'b1, SYNC_WORD[23:16]};
				end else if (st_reg.hdr_pos < CTRL_FIRST) begin
					wr_data = {1'b0, SYNC_WORD[15:8]};
				end else begin
					wr_data = {1'b0, st_reg.ctrl[(4 - cidx) * 8 +: 8]};
				end
				if (wr_ready) begin
					st_next.hdr_pos = st_reg.hdr_pos + 1'b1;
					if (st_reg.hdr_pos == HDR_LAST) begin
						st_next.state    = SUFP_SAMP;
						st_next.grp_cnt  = 6'h00;
						st_next.byte_pos = 3'h0;
						st_next.have_grp = 1'b0;
					end
				end
			end
			SUFP_SAMP: begin
				if (!st_reg.have_grp) begin
					if (grp_valid) begin
						// group word of 24, 24 and 16 bits
						st_next.grp      = {grp_i, grp_q, grp_mic};
						st_next.have_grp = 1'b1;
					end else begin
						st_next.wait_cnt = st_reg.wait_cnt + 1'b1;
					end
				end else begin
					wr_valid = 1'b1;
					wr_data = {1'b0, st_reg.grp[(7 - st_reg.byte_pos) * 8 +: 8]};
					if (wr_ready) begin
						st_next.byte_pos = st_reg.byte_pos + 1'b1;
						if (st_reg.byte_pos == GRP_LAST) begin
							st_next.have_grp = 1'b0;
							if (st_reg.grp_cnt == GROUPS - 6'h01) begin
								st_next.state   = SUFP_IDLE;
								st_next.seq_cnt = st_reg.seq_cnt + 1'b1;
							end else begin
								st_next.grp_cnt = st_reg.grp_cnt + 1'b1;
							end
						end
					end
				end
			end
			default: begin
				st_next.state = SUFP_IDLE;
			end
		endcase

		if (wr_valid && !wr_ready) begin
			st_next.full_cnt = st_reg.full_cnt + 1'b1;
		end
		// an arrival in the cycle of consumption keeps the flag set
		if (pwr_valid) begin
			st_next.pwr_avail = 1'b1;
		end
		if (freq_valid) begin
			st_next.freq_avail = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg           <= '0;
			st_reg.state     <= SUFP_IDLE;
			st_reg.ptt_sync  <= SYNC_RST;
			st_reg.dash_sync <= SYNC_RST;
			st_reg.ptt_lvl   <= 1'b1;
			st_reg.dash_lvl  <= 1'b1;
			st_reg.full_cnt  <= CNT_RST;
			st_reg.wait_cnt  <= CNT_RST;
			st_reg.seq_cnt   <= CNT_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// output buffer
	// ----------------------------------------------------------------
	// the sequencer stalls on a full fifo instead of dropping bytes
	sufp_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (clk),
		.arst_n    (arst_n),
		.in_valid  (wr_valid),
		.in_ready  (wr_ready),
		.in_data   (wr_data),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (rd_data),
		.level     (fifo_level)
	);
endmodule : sufp_frame_packer

/* File: design/sufp_pkg.sv */
// constants and types of the uplink frame packer
package sufp_pkg;
	// ----------------------------------------------------------------
	// frame layout
	// ----------------------------------------------------------------
	localparam int unsigned FRAME_BYTES = 512;
	localparam int unsigned HDR_BYTES   = 8;
	localparam int unsigned SYNC_BYTES  = 3;
	localparam int unsigned CTRL_BYTES  = 5;
	localparam int unsigned GROUP_BYTES = 8;
	localparam logic [5:0]  GROUPS      = 6'h3f;
	localparam logic [23:0] SYNC_WORD   = 24'h80_0000;
	localparam logic [7:0]  SYNC_LEAD   = SYNC_WORD[23:16];
	localparam logic [7:0]  SYNC_TAIL   = SYNC_WORD[15:8];
	localparam logic [7:0]  SYNC_SAFE   = 8'h7f;
	localparam logic [2:0]  HDR_LAST    = 3'h7;
	localparam logic [2:0]  CTRL_FIRST  = 3'h3;
	localparam logic [2:0]  GRP_LAST    = 3'h7;

	// ----------------------------------------------------------------
	// sample widths
	// ----------------------------------------------------------------
	localparam int unsigned IQ_W  = 24;
	localparam int unsigned MIC_W = 16;
	localparam int unsigned GRP_W = 2 * IQ_W + MIC_W;

	// ----------------------------------------------------------------
	// control byte zero fields and pages
	// ----------------------------------------------------------------
	localparam int unsigned PTT_BIT  = 0;
	localparam int unsigned DASH_BIT = 1;
	localparam int unsigned SEL_LSB  = 2;
	localparam logic [2:0] PAGE_DEBUG = 3'h0;
	localparam logic [2:0] PAGE_POWER = 3'h1;
	localparam logic [2:0] PAGE_PPORT = 3'h2;
	localparam logic [2:0] PAGE_FREQ  = 3'h3;
	localparam logic [2:0] PAGE_USER  = 3'h4;

	// ----------------------------------------------------------------
	// buffering and reset values
	// ----------------------------------------------------------------
	localparam int unsigned FIFO_DEPTH = 32;
	localparam int unsigned FIFO_WIDTH = 9;
	localparam logic [2:0]  SYNC_RST   = 3'h7;
	localparam logic [7:0]  CNT_RST    = 8'h00;

	typedef enum logic [2:0] {
		SUFP_IDLE = 3'b001,
		SUFP_HEAD = 3'b010,
		SUFP_SAMP = 3'b100
	} sufp_state_t;
endpackage : sufp_pkg

/* File: tb/sufp_checker.sv */
// concurrent checks on the frame packer ports
`timescale 1ns/1ps
module sufp_checker
	import sufp_pkg::*;
(
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic       grp_valid,
	input wire logic       grp_ready,
	input wire logic       out_valid,
	input wire logic       out_ready,
	input wire logic [7:0] out_data,
	input wire logic       out_sof
);
	logic [8:0] pos_reg;
	logic       pop;
	// ----------------------------------------------------------------
	// byte position within the frame, counted on pops
	// ----------------------------------------------------------------
	assign pop = out_valid && out_ready;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pos_reg <= 9'h000;
		end else if (pop) begin
			pos_reg <= pos_reg + 9'h001;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_sof_at_zero; pop && out_sof |-> pos_reg == 9'h000; endproperty
	property p_zero_has_sof; pop && pos_reg == 9'h000 |-> out_sof; endproperty
	property p_no_sof_mid; out_valid && pos_reg != 9'h000 |-> !out_sof; endproperty
	property p_sync_lead; out_valid && out_sof |-> out_data == SYNC_LEAD; endproperty
	property p_sync_tail;
		pop && (pos_reg == 9'h001 || pos_reg == 9'h002) |-> out_data == 8'h00;
	endproperty
	property p_last_ctrl_safe; pop && pos_reg == 9'h007 |-> out_data != SYNC_LEAD; endproperty
	property p_hold;
		out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_sof);
	endproperty
	// a taken group needs eight output bytes before the next
	property p_grp_gap; grp_valid && grp_ready |=> !grp_ready [*8]; endproperty
	a_sof_at_zero: assert property (p_sof_at_zero) else $error("sof off frame start");
	a_zero_has_sof: assert property (p_zero_has_sof) else $error("frame start lacks sof");
	a_no_sof_mid: assert property (p_no_sof_mid) else $error("sof inside frame");
	a_sync_lead: assert property (p_sync_lead) else $error("bad sync lead byte");
	a_sync_tail: assert property (p_sync_tail) else $error("bad sync tail byte");
	a_last_ctrl_safe: assert property (p_last_ctrl_safe) else $error("last ctrl byte mimics sync");
	a_hold: assert property (p_hold) else $error("byte changed while stalled");
	a_grp_gap: assert property (p_grp_gap) else $error("groups taken too close");
	c_frame: cover property (pop && out_sof);
	c_take: cover property (grp_valid && grp_ready);
	c_stall: cover property (out_valid && !out_ready);
endmodule : sufp_checker

bind sufp_frame_packer sufp_checker sufp_checker_i (.clk, .arst_n, .grp_valid, .grp_ready,
	.out_valid, .out_ready, .out_data, .out_sof);

/* File: tb/sufp_host_model.sv */
// host side byte sink: usb bridge fifo model
`timescale 1ns/1ps
module sufp_host_model (
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic       out_valid,
	input wire logic       out_sof,
	input wire logic [7:0] out_data,
	input wire logic       slow,
	output logic           out_ready,
	output logic           sync_lost
);
	logic [7:0] rx_q[$];
	logic [8:0] cnt;
	logic       ph;
	// slow host accepts every other cycle so the device fifo fills
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			out_ready <= 1'b0;
			sync_lost <= 1'b0;
			ph <= 1'b0;
			cnt <= 9'h000;
		end else begin
			ph <= ~ph;
			out_ready <= slow ? ph : 1'b1;
			if (out_valid && out_ready) begin
				rx_q.push_back(out_data);
				cnt <= cnt + 9'h001;
				if (out_sof && cnt != 9'h000) begin
					sync_lost <= 1'b1;
				end
			end
		end
	end
endmodule : sufp_host_model

/* File: tb/sufp_frame_packer_test.sv */
// self-checking bench of the uplink frame packer
`timescale 1ns/1ps
module sufp_frame_packer_test;
	import sufp_pkg::*;
	logic              clk, arst_n, grp_valid, grp_ready, ptt_n, dash_n, pwr_valid;
	logic              out_valid, out_ready, out_sof, slow;
	logic              freq_valid;
	logic [31:0]       freq;
	logic [IQ_W-1:0]   gi, gq;
	logic [MIC_W-1:0]  gm;
	logic [15:0]       fwd, rev, pport;
	logic [7:0]        user, out_data;
	int                error_cnt, cmp_count, cyc;

	sufp_frame_packer sufp_frame_packer_i (.clk(clk), .arst_n(arst_n), .grp_valid(grp_valid),
		.grp_ready(grp_ready), .grp_i(gi), .grp_q(gq), .grp_mic(gm), .push_to_talk_n(ptt_n),
		.dash_n(dash_n), .pwr_valid(pwr_valid), .fwd_pwr(fwd), .rev_pwr(rev),
		.freq_valid(freq_valid), .freq_count(freq), .pport_in(pport), .user_in(user),
		.out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_sof(out_sof));
	sufp_host_model sufp_host_model_i (.clk(clk), .arst_n(arst_n), .out_valid(out_valid),
		.out_sof(out_sof), .out_data(out_data), .slow(slow), .out_ready(out_ready),
		.sync_lost());

	always #2 clk = ~clk;
	// nine frames, one of them at half rate, stay far below this ceiling
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end

	task wrap_up;
		$display("compares %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : wrap_up

	task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask : chk8

	// group k carries a pattern built from k so order and gaps show
	function automatic logic [7:0] exp_byte(input int n, input logic [39:0] hdr);
		logic [7:0]  g;
		logic [63:0] grp;
		g = 8'((n - 8) / 8);
		grp = {g, 8'hc3, g + 8'h01, ~g, g, 8'h3c, g, ~g};
		if (n < 3) return (n == 0) ? 8'h80 : 8'h00;
		if (n < 8) return hdr[8*(7-n)+:8];
		return grp[8*(7-(n%8))+:8];
	endfunction : exp_byte

	task automatic run_frame(input logic [39:0] hdr, input bit chk_c);
		logic [7:0] g;
		logic [7:0] b;
		repeat (8) @(negedge clk);
		for (int k = 0; k < 63; k++) begin
			g = 8'(k);
			gi = {g, 8'hc3, g + 8'h01};
			gq = {~g, g, 8'h3c};
			gm = {g, ~g};
			grp_valid = 1'b1;
			while (grp_ready !== 1'b1) @(negedge clk);
			@(negedge clk);
		end
		grp_valid = 1'b0;
		while (sufp_host_model_i.rx_q.size() < 512) @(negedge clk);
		for (int n = 0; n < 512; n++) begin
			b = sufp_host_model_i.rx_q.pop_front();
			if (chk_c || n < 4 || n > 7) chk8("frame byte", exp_byte(n, hdr), b);
		end
		chk8("sync spacing", 8'h00, {7'h00, sufp_host_model_i.sync_lost});
	endtask : run_frame

	task t_plain_ptt;
		ptt_n = 1'b0;
		// first frame after reset: every debug counter and the fifo level are still zero
		run_frame({8'h01, 32'h0000_0000}, 1'b1);
	endtask : t_plain_ptt

	task t_power_slow_host;
		ptt_n = 1'b1;
		dash_n = 1'b0;
		fwd = 16'h1234;
		rev = 16'h5680;
		pwr_valid = 1'b1;
		@(negedge clk);
		pwr_valid = 1'b0;
		slow = 1'b1;
		run_frame({8'h06, 8'h12, 8'h34, 8'h56, 8'h7f}, 1'b1);
		slow = 1'b0;
	endtask : t_power_slow_host

	task t_pport_guard;
		dash_n = 1'b1;
		pport = 16'h8000;
		run_frame({8'h08, 8'h7f, 24'h00_0000}, 1'b1);
	endtask : t_pport_guard

	task t_freq_absent;
		run_frame({8'h00, 32'h0000_0000}, 1'b0);
	endtask : t_freq_absent

	task t_user;
		user = 8'ha5;
		run_frame({8'h10, 8'ha5, 24'h00_0000}, 1'b1);
	endtask : t_user

	// frequency stays pending through the debug, empty power and parallel port slots
	task t_freq_present;
		freq = 32'hdead_beef;
		freq_valid = 1'b1;
		@(negedge clk);
		freq_valid = 1'b0;
		run_frame({8'h00, 32'h0000_0000}, 1'b0);
		run_frame({8'h00, 32'h0000_0000}, 1'b0);
		run_frame({8'h08, 8'h7f, 24'h00_0000}, 1'b1);
		run_frame({8'h0c, 32'hdead_beef}, 1'b1);
	endtask : t_freq_present

	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		{grp_valid, pwr_valid, freq_valid, slow} = 4'h0;
		freq = 32'h0000_0000;
		{ptt_n, dash_n} = 2'b11;
		{gi, gq, gm, fwd, rev, pport, user} = '0;
		repeat (20) @(negedge clk);
		arst_n = 1'b1;
		t_plain_ptt();
		t_power_slow_host();
		t_pport_guard();
		t_freq_absent();
		t_user();
		t_freq_present();
		wrap_up();
	end
endmodule : sufp_frame_packer_test
